// [agu_pkg.sv]
// shared constants and carrier types for the stack check and program agu
package agu_pkg;
    localparam int DATA_W = 16;
    localparam int PROG_W = 24;
    localparam int PAGE_W = 8;
    // register indices on the plain register port
    localparam logic [3:0] REG_STACK_PTR  = 4'h0;
    localparam logic [3:0] REG_STACK_LIM  = 4'h1;
    localparam logic [3:0] REG_TABLE_PAGE = 4'h2;
    localparam logic [3:0] REG_WIN_PAGE   = 4'h3;
    localparam logic [3:0] REG_CORE_CTRL  = 4'h4;
    localparam logic [3:0] REG_STATUS     = 4'h5;
    localparam int CTRL_WIN_EN_BIT = 2;
    localparam logic [15:0] SP_RESET      = 16'h0800;
    localparam logic [15:0] SFR_BOUNDARY  = 16'h0800;
    localparam logic [15:0] DATA_MSB_MASK = 16'h8000;
    localparam logic [7:0]  PAGE_RESET    = 8'h00;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;

    typedef enum logic [3:0] {
        ST_OP_NONE = 4'b0001,
        ST_OP_PUSH = 4'b0010,
        ST_OP_POP  = 4'b0100,
        ST_OP_EA   = 4'b1000
    } stack_op_e;

    typedef enum logic [1:0] {
        PUSH_DATA = 2'h0,
        PUSH_CALL = 2'h1,
        PUSH_EXC  = 2'h2
    } push_kind_e;

    typedef struct packed {
        logic        valid;
        logic        is_table;
        logic        is_write;
        logic        is_fetch;
        logic [15:0] ea;
        logic [23:0] pc;
    } prog_req_s;

    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
        logic        config_space;
        logic        write;
        logic        low_word_only;
        logic        is_data_space;
        logic        refused;
    } prog_addr_s;
endpackage : agu_pkg

// [stack_limit_cmp.sv]
// comparator that flags a stack address beyond the limit or below sfr space
`timescale 1ns/10ps
`default_nettype none
module stack_limit_cmp
    import agu_pkg::*;
#(
    parameter int W = 16
) (
    // compared values
    input  wire logic [W-1:0] i_addr,
    input  wire logic [W-1:0] i_limit,
    input  wire logic [W-1:0] i_floor,
    // results
    output logic              o_over,
    output logic              o_under
);
    initial begin
        if (W < 2) $error("stack_limit_cmp width too small");
    end
    assign o_over  = i_addr > i_limit;
    assign o_under = i_addr < i_floor;
endmodule : stack_limit_cmp
`default_nettype wire

// [prog_addr_gen.sv]
// combinational program-space address builder for table, window and fetch
`timescale 1ns/10ps
`default_nettype none
module prog_addr_gen
    import agu_pkg::*;
(
    // request
    input  wire logic       i_is_table,
    input  wire logic       i_is_fetch,
    input  wire logic [15:0] i_ea,
    input  wire logic [23:0] i_pc,
    input  wire logic [7:0]  i_table_page,
    input  wire logic [7:0]  i_win_page,
    // result
    output logic [23:0]      o_addr
);
    always_comb begin
        if (i_is_fetch) begin
            o_addr = {1'b0, i_pc[22:1], 1'b0};
        end else if (i_is_table) begin
            o_addr = {i_table_page, i_ea};
        end else begin
            // ea bit 15 dropped; page bit 0 lands on address bit 15
            o_addr = {1'b0, i_win_page, i_ea[14:1], 1'b0};
        end
    end
endmodule : prog_addr_gen
`default_nettype wire

// [stack_agu.sv]
// stack pointer with limit and underflow traps, program-space address unit
// Operation
// - stack pointer addresses next free word; stack grows upward
// - pop predecrements before read; push postincrements after write
// - call push zero-fills the upper pc byte
// - exception push puts status low byte in the upper pc byte
// - limit bit zero held zero; limit not initialised at reset
// - every stack-pointer effective address is compared with the limit; only push and ea raise the stack trap
// - push at pointer equal to limit is allowed; next push traps
// - pointer below special-register boundary raises underflow trap
// - wide program space, narrow data space, data may live in program
// - table address is table page above the data effective address
// - table page top bit picks user or configuration memory
// - window address joins window page with low effective-address bits
// - window accesses stay in user memory; top bit forced zero
// - window ignores ea bit 15; page bit zero drives address bit 15
// - window and fetch addresses have bit zero forced zero
// - table accesses may use any byte address
// - table reads may reach configuration memory
// - window is read-only, returns low word of program word only
// - table accesses reach every byte including the upper byte
// - window maps only while the core control enable bit is set
// - window suspended while a table read or write is in progress
// - table writes to configuration memory are not carried out
`timescale 1ns/10ps
`default_nettype none
module stack_agu
    import agu_pkg::*;
(
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    // register port
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic [15:0]      o_reg_rdata,
    // stack operations from the pipeline
    input  wire logic [3:0]  i_stack_op,
    input  wire logic [1:0]  i_push_kind,
    input  wire logic [15:0] i_push_data,
    input  wire logic [23:0] i_push_pc,
    input  wire logic [7:0]  i_status_low,
    input  wire logic [15:0] i_sp_ea,
    // stack memory access
    output logic             o_stack_mem_valid,
    output logic             o_stack_mem_write,
    output logic [15:0]      o_stack_mem_addr,
    output logic [31:0]      o_stack_mem_wdata,
    output logic             o_stack_trap,
    output logic             o_underflow_trap,
    // program-space access
    input  wire prog_req_s   i_prog_req,
    input  wire logic        i_table_busy,
    output prog_addr_s       o_prog
);
    logic [15:0] stack_ptr;
    logic [15:0] stack_lim;
    logic [7:0]  table_page;
    logic [7:0]  win_page;
    logic [15:0] core_ctrl;
    logic [15:0] next_stack_ptr;
    logic [15:0] chk_addr;
    logic        over;
    logic        under;
    logic        sp_wr;
    logic        lim_wr;
    logic        is_push;
    logic        is_pop;
    logic        is_ea;
    logic [23:0] gen_addr;
    logic        win_hit;
    logic        win_en;
    logic        sticky_trap;
    logic        sticky_under;

    assign is_push = i_stack_op == ST_OP_PUSH;
    assign is_pop  = i_stack_op == ST_OP_POP;
    assign is_ea   = i_stack_op == ST_OP_EA;
    assign sp_wr   = i_reg_wr && (i_reg_addr == REG_STACK_PTR);
    assign lim_wr  = i_reg_wr && (i_reg_addr == REG_STACK_LIM);
    assign win_en  = core_ctrl[CTRL_WIN_EN_BIT];

    always_comb begin
        next_stack_ptr = stack_ptr;
        if (is_push) begin
            next_stack_ptr = stack_ptr + 16'h0002;
        end else if (is_pop) begin
            next_stack_ptr = stack_ptr - 16'h0002;
        end
    end

    // push checks the slot being written, so equal-to-limit passes
    always_comb begin
        chk_addr = stack_ptr;
        if (is_pop) begin
            chk_addr = next_stack_ptr;
        end else if (is_ea) begin
            chk_addr = i_sp_ea;
        end
    end

    stack_limit_cmp #(
        .W (DATA_W)
    ) u_cmp (
        .i_addr  (chk_addr),
        .i_limit (stack_lim),
        .i_floor (SFR_BOUNDARY),
        .o_over  (over),
        .o_under (under)
    );

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            stack_ptr <= SP_RESET;
        end else if (sp_wr) begin
            stack_ptr <= {i_reg_wdata[15:1], 1'b0};
        end else if (is_push || is_pop) begin
            stack_ptr <= next_stack_ptr;
        end
    end

    // no reset branch: the limit powers up unknown by design
    always_ff @(posedge i_core_clk) begin
        if (lim_wr) begin
            stack_lim <= {i_reg_wdata[15:1], 1'b0};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            table_page <= PAGE_RESET;
            win_page   <= PAGE_RESET;
            core_ctrl  <= CTRL_RESET;
        end else if (i_reg_wr) begin
            if (i_reg_addr == REG_TABLE_PAGE) begin
                table_page <= i_reg_wdata[7:0];
            end else if (i_reg_addr == REG_WIN_PAGE) begin
                win_page <= i_reg_wdata[7:0];
            end else if (i_reg_addr == REG_CORE_CTRL) begin
                core_ctrl <= i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_stack_mem_valid <= 1'b0;
            o_stack_mem_write <= 1'b0;
            o_stack_mem_addr  <= 16'h0000;
            o_stack_mem_wdata <= 32'h0000_0000;
            o_stack_trap      <= 1'b0;
            o_underflow_trap  <= 1'b0;
        end else begin
            o_stack_mem_valid <= is_push || is_pop;
            o_stack_mem_write <= is_push;
            o_stack_mem_addr  <= is_pop ? next_stack_ptr : stack_ptr;
            if (is_push) begin
                if (i_push_kind == PUSH_CALL) begin
                    o_stack_mem_wdata <= {8'h00, i_push_pc};
                end else if (i_push_kind == PUSH_EXC) begin
                    o_stack_mem_wdata <= {i_status_low, i_push_pc};
                end else begin
                    o_stack_mem_wdata <= {16'h0000, i_push_data};
                end
            end
            o_stack_trap     <= (is_push || is_ea) && over;
            o_underflow_trap <= (is_push || is_pop || is_ea) && under;
        end
    end

    // sticky copies for software; a new trap wins over a status clear
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            sticky_trap  <= 1'b0;
            sticky_under <= 1'b0;
        end else begin
            if (o_stack_trap) begin
                sticky_trap <= 1'b1;
            end else if (i_reg_wr && i_reg_addr == REG_STATUS
                         && i_reg_wdata[0]) begin
                sticky_trap <= 1'b0;
            end
            if (o_underflow_trap) begin
                sticky_under <= 1'b1;
            end else if (i_reg_wr && i_reg_addr == REG_STATUS
                         && i_reg_wdata[1]) begin
                sticky_under <= 1'b0;
            end
        end
    end

    prog_addr_gen u_gen (
        .i_is_table   (i_prog_req.is_table),
        .i_is_fetch   (i_prog_req.is_fetch),
        .i_ea         (i_prog_req.ea),
        .i_pc         (i_prog_req.pc),
        .i_table_page (table_page),
        .i_win_page   (win_page),
        .o_addr       (gen_addr)
    );

    // window only for data accesses with ea msb set, enabled, no table busy
    assign win_hit = !i_prog_req.is_table && !i_prog_req.is_fetch
                     && ((i_prog_req.ea & DATA_MSB_MASK) != 16'h0000)
                     && win_en && !i_table_busy;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_prog <= '0;
        end else begin
            o_prog.valid         <= 1'b0;
            o_prog.addr          <= gen_addr;
            o_prog.config_space  <= 1'b0;
            o_prog.write         <= 1'b0;
            o_prog.low_word_only <= 1'b0;
            o_prog.is_data_space <= 1'b0;
            o_prog.refused       <= 1'b0;
            if (i_prog_req.valid) begin
                if (i_prog_req.is_fetch) begin
                    o_prog.valid <= 1'b1;
                end else if (i_prog_req.is_table) begin
                    o_prog.config_space <= table_page[PAGE_W-1];
                    if (i_prog_req.is_write && table_page[PAGE_W-1]) begin
                        o_prog.refused <= 1'b1;
                    end else begin
                        o_prog.valid <= 1'b1;
                        o_prog.write <= i_prog_req.is_write;
                    end
                end else if (win_hit) begin
                    if (i_prog_req.is_write) begin
                        o_prog.refused <= 1'b1;
                    end else begin
                        o_prog.valid         <= 1'b1;
                        o_prog.low_word_only <= 1'b1;
                    end
                end else begin
                    o_prog.is_data_space <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_reg_rd) begin
            if (i_reg_addr == REG_STACK_PTR) begin
                o_reg_rdata <= stack_ptr;
            end else if (i_reg_addr == REG_STACK_LIM) begin
                o_reg_rdata <= stack_lim;
            end else if (i_reg_addr == REG_TABLE_PAGE) begin
                o_reg_rdata <= {8'h00, table_page};
            end else if (i_reg_addr == REG_WIN_PAGE) begin
                o_reg_rdata <= {8'h00, win_page};
            end else if (i_reg_addr == REG_CORE_CTRL) begin
                o_reg_rdata <= core_ctrl;
            end else if (i_reg_addr == REG_STATUS) begin
                o_reg_rdata <= {14'h0000, sticky_under, sticky_trap};
            end else begin
                o_reg_rdata <= 16'h0000;
            end
        end else begin
            o_reg_rdata <= 16'h0000;
        end
    end
endmodule : stack_agu
`default_nettype wire

// [stack_agu_monitor.sv]
// concurrent checks on the ports of the stack and program address unit
`timescale 1ns/10ps
`default_nettype none
module stack_agu_monitor
    import agu_pkg::*;
(
    // watched ports
    input wire logic        i_core_clk,
    input wire logic        i_reset_n,
    input wire logic        i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire logic [3:0]  i_stack_op,
    input wire logic [1:0]  i_push_kind,
    input wire logic [23:0] i_push_pc,
    input wire logic [7:0]  i_status_low,
    input wire logic        o_stack_mem_write,
    input wire logic [15:0] o_stack_mem_addr,
    input wire logic [31:0] o_stack_mem_wdata,
    input wire prog_req_s   i_prog_req,
    input wire logic        i_table_busy,
    input wire prog_addr_s  o_prog
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    wire logic        psh = i_stack_op == ST_OP_PUSH;
    wire logic        pop = i_stack_op == ST_OP_POP;
    wire logic [15:0] ea  = i_prog_req.ea;
    wire logic        win = i_prog_req.valid && ea[15]
                            && !i_prog_req.is_table && !i_prog_req.is_fetch;
    sequence s_push2;
        psh ##1 psh;
    endsequence
    sequence s_push_pop;
        psh ##1 pop;
    endsequence
    a_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == 16'h0000)
        else $error("read data not zero");
    a_push_step: assert property (s_push2 |=>
        o_stack_mem_addr == $past(o_stack_mem_addr) + 16'h0002)
        else $error("push did not advance by one word");
    a_pop_predec: assert property (s_push_pop |=>
        o_stack_mem_addr == $past(o_stack_mem_addr) && !o_stack_mem_write)
        else $error("pop did not read the last pushed word");
    a_call_zero: assert property (psh && i_push_kind == PUSH_CALL |=>
        o_stack_mem_wdata == {8'h00, $past(i_push_pc)})
        else $error("call push upper byte not zero");
    a_exc_status: assert property (psh && i_push_kind == PUSH_EXC |=>
        o_stack_mem_wdata == {$past(i_status_low), $past(i_push_pc)})
        else $error("exception push lacks status byte");
    a_fetch_align: assert property (i_prog_req.valid && i_prog_req.is_fetch
        |=> o_prog.addr == {1'b0, $past(i_prog_req.pc[22:1]), 1'b0})
        else $error("fetch address wrong");
    a_table_join: assert property (i_prog_req.valid && i_prog_req.is_table
        |=> o_prog.addr[15:0] == $past(ea)
            && o_prog.config_space == o_prog.addr[23])
        else $error("table address wrong");
    a_win_user: assert property (win && !i_table_busy
        && !i_prog_req.is_write |=> !o_prog.valid || (!o_prog.addr[23]
        && !o_prog.addr[0] && o_prog.addr[14:1] == $past(ea[14:1])))
        else $error("window address wrong");
    a_win_busy: assert property (win && i_table_busy |=> !o_prog.valid)
        else $error("window used during table access");
    a_cfg_nowrite: assert property (i_prog_req.valid && i_prog_req.is_table
        && i_prog_req.is_write |=> !o_prog.config_space || o_prog.refused)
        else $error("config write carried out");
endmodule : stack_agu_monitor
bind stack_agu stack_agu_monitor mon (.*);
`default_nettype wire

// [stack_ram_model.sv]
// behavioural stack memory behind the unit, 64 words deep
`timescale 1ns/10ps
`default_nettype none
module stack_ram_model (
    // stack memory port
    input  wire logic        i_core_clk,
    input  wire logic        i_valid,
    input  wire logic        i_write,
    input  wire logic [15:0] i_addr,
    input  wire logic [31:0] i_wdata,
    // word at the address
    output logic [31:0]      o_rdata
);
    logic [31:0] mem [0:63];
    logic [63:0] vld = 64'h0;
    // never-written words read back scrambled, not as a lucky zero
    assign o_rdata = vld[i_addr[6:1]] ? mem[i_addr[6:1]] : ~i_wdata;
    always @(posedge i_core_clk) begin
        if (i_valid && i_write) begin
            mem[i_addr[6:1]] <= i_wdata;
            vld[i_addr[6:1]] <= 1'b1;
        end
    end
endmodule : stack_ram_model
`default_nettype wire

// [tb_stack_agu.sv]
// self-checking bench for the stack and program address unit
`timescale 1ns/10ps
`default_nettype none
module tb_stack_agu
    import agu_pkg::*;
;
    typedef struct packed {
        logic        w;
        logic [15:0] a;
        logic [31:0] d;
    } mem_exp_s;
    logic        i_core_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic [3:0]  i_reg_addr = 4'h0;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic        i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0;
    logic [3:0]  i_stack_op = ST_OP_NONE;
    logic [1:0]  i_push_kind = PUSH_DATA;
    logic [15:0] i_push_data = 16'h0000;
    logic [23:0] i_push_pc = 24'h00_0000;
    logic [7:0]  i_status_low = 8'h00;
    logic [15:0] i_sp_ea = 16'h0000;
    prog_req_s   i_prog_req = '0;
    logic        i_table_busy = 1'b0;
    logic [15:0] o_reg_rdata;
    logic        o_stack_mem_valid;
    logic        o_stack_mem_write;
    logic [15:0] o_stack_mem_addr;
    logic [31:0] o_stack_mem_wdata;
    logic        o_stack_trap;
    logic        o_underflow_trap;
    prog_addr_s  o_prog;
    logic [31:0] ram_word;
    int          miscompares = 0;
    int          compares = 0;
    logic [31:0] seed = 32'h7537_5d22;
    logic [31:0] rv;
    logic [7:0]  tp = 8'h85;
    logic [7:0]  wp;
    // limit the bench programs; bit zero of the written value is dropped
    localparam logic [15:0] LIM = 16'h1002;
    logic        rd_d = 1'b0;
    logic        ov = 1'b0;
    logic        pv = 1'b0;
    logic [15:0] rq[$];
    mem_exp_s    mq[$];
    mem_exp_s    e;
    logic [1:0]  tq[$];
    logic [29:0] pq[$];
    logic [29:0] pe;
    logic [31:0] shadow [0:63];
    wire logic [1:0] traps = {o_underflow_trap, o_stack_trap};
    wire logic [5:0] pflags = {o_prog.valid, o_prog.write,
                               o_prog.is_data_space, o_prog.refused,
                               o_prog.config_space, o_prog.low_word_only};
    stack_agu dut (.*);
    stack_ram_model ram (
        .i_core_clk (i_core_clk),
        .i_valid    (o_stack_mem_valid),
        .i_write    (o_stack_mem_write),
        .i_addr     (o_stack_mem_addr),
        .i_wdata    (o_stack_mem_wdata),
        .o_rdata    (ram_word)
    );
    always #2 i_core_clk = ~i_core_clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_core_clk);
        i_reg_wr    <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [15:0] x);
        @(posedge i_core_clk);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        rq.push_back(x);
        @(posedge i_core_clk);
        i_reg_rd   <= 1'b0;
    endtask : rd
    // ops chain back to back; end a chain with a none op
    task op(input stack_op_e o, input push_kind_e k, input logic [15:0] a,
            input logic ck);
        logic [31:0] r;
        logic [31:0] w;
        r = xs();
        w = k == PUSH_DATA ? {16'h0000, r[15:0]}
          : k == PUSH_CALL ? {8'h00, r[23:0]} : r;
        @(posedge i_core_clk);
        i_stack_op   <= o;
        i_push_kind  <= k;
        i_push_data  <= r[15:0];
        i_push_pc    <= r[23:0];
        i_status_low <= r[31:24];
        i_sp_ea      <= a;
        if (o == ST_OP_PUSH)
            shadow[a[6:1]] = w;
        else if (ck)
            w = shadow[a[6:1]];
        if (ck)
            mq.push_back({o == ST_OP_PUSH, a, w});
        // a is the slot for push and pop, the checked address for ea
        if (o != ST_OP_NONE)
            tq.push_back({a < SFR_BOUNDARY, o != ST_OP_POP && a > LIM});
    endtask : op
    // kind: 0 fetch, 1/2 table read/write, 3/4 window read/write, 5 idle
    // m: window mapping is on (enable set, no table busy)
    task req(input int k, input logic b, input logic m);
        logic [31:0] r;
        logic [15:0] ea;
        logic [23:0] wa;
        logic        cf;
        r  = xs();
        ea = k >= 3 ? {1'b1, r[14:0]} : r[15:0];
        wa = {1'b0, wp, ea[14:1], 1'b0};
        cf = (k == 1 || k == 2) && tp[7];
        @(posedge i_core_clk);
        i_prog_req   <= {k != 5, k == 1 || k == 2, k == 2 || k == 4,
                         k == 0, ea, r[31:8]};
        i_table_busy <= b;
        // flags: valid, write, data space, refused, config, low word
        if (k == 0)
            pq.push_back({6'h20, 1'b0, r[30:9], 1'b0});
        else if (k < 3)
            pq.push_back({!(k == 2 && cf), k == 2 && !cf, 1'b0,
                          k == 2 && cf, cf, 1'b0, tp, ea});
        else if (k < 5)
            pq.push_back({k == 3 && m, 1'b0, !m, k == 4 && m, 1'b0,
                          k == 3 && m, wa});
    endtask : req
    always @(posedge i_core_clk) begin
        rd_d <= i_reg_rd;
        ov   <= i_stack_op != ST_OP_NONE;
        pv   <= i_prog_req.valid;
    end
    always @(negedge i_core_clk) begin
        if (rd_d)
            chk("reg read", o_reg_rdata, rq.pop_front());
        if (o_stack_mem_valid && mq.size() > 0) begin
            e = mq.pop_front();
            chk("mem addr", o_stack_mem_addr, e.a);
            chk("mem write", o_stack_mem_write, e.w);
            chk("mem word", e.w ? o_stack_mem_wdata : ram_word, e.d);
        end
        if (ov)
            chk("traps", traps, tq.pop_front());
        if (pv) begin
            pe = pq.pop_front();
            chk("prog flags", pflags, pe[29:24]);
            if (pe[29])
                chk("prog addr", o_prog.addr, pe[23:0]);
        end
    end
    initial begin
        rv = xs();
        wp = rv[7:0];
        repeat (8) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        rd(REG_STACK_PTR, SP_RESET);
        rd(REG_TABLE_PAGE, 16'h0000);
        rd(REG_CORE_CTRL, CTRL_RESET);
        rd(4'hf, 16'h0000);
        wr(REG_STACK_LIM, 16'h1003);
        rd(REG_STACK_LIM, LIM); // gap after limit write
        wr(REG_STACK_PTR, 16'h1001);
        rd(REG_STACK_PTR, 16'h1000);
        op(ST_OP_PUSH, PUSH_DATA, 16'h1000, 1'b1);
        op(ST_OP_PUSH, PUSH_CALL, 16'h1002, 1'b1);
        op(ST_OP_POP, PUSH_DATA, 16'h1002, 1'b1);
        op(ST_OP_PUSH, PUSH_EXC, 16'h1002, 1'b1);
        op(ST_OP_NONE, PUSH_DATA, 16'h0000, 1'b0);
        rd(REG_STATUS, 16'h0000);
        op(ST_OP_PUSH, PUSH_DATA, 16'h1004, 1'b0);
        op(ST_OP_NONE, PUSH_DATA, 16'h0000, 1'b0);
        rd(REG_STATUS, 16'h0001);
        wr(REG_STATUS, 16'h0001);
        op(ST_OP_EA, PUSH_DATA, 16'h1002, 1'b0);
        op(ST_OP_NONE, PUSH_DATA, 16'h0000, 1'b0);
        rd(REG_STATUS, 16'h0000);
        op(ST_OP_EA, PUSH_DATA, 16'h1004, 1'b0);
        op(ST_OP_NONE, PUSH_DATA, 16'h0000, 1'b0);
        rd(REG_STATUS, 16'h0001);
        wr(REG_STACK_PTR, SP_RESET);
        op(ST_OP_POP, PUSH_DATA, 16'h07fe, 1'b0);
        op(ST_OP_NONE, PUSH_DATA, 16'h0000, 1'b0);
        rd(REG_STATUS, 16'h0003);
        wr(REG_TABLE_PAGE, {8'h00, tp});
        wr(REG_WIN_PAGE, {8'h00, wp});
        wr(REG_CORE_CTRL, 16'h0004);
        req(0, 1'b0, 1'b1);
        req(1, 1'b0, 1'b1);
        req(2, 1'b0, 1'b0);
        req(3, 1'b0, 1'b1);
        req(3, 1'b1, 1'b0);
        req(4, 1'b0, 1'b1);
        req(5, 1'b0, 1'b0);
        wr(REG_CORE_CTRL, 16'h0000);
        req(3, 1'b0, 1'b0);
        req(5, 1'b0, 1'b0);
        tp = 8'h12;
        wr(REG_TABLE_PAGE, {8'h00, tp});
        req(2, 1'b0, 1'b1);
        req(5, 1'b0, 1'b0);
        repeat (4) @(posedge i_core_clk);
        test_done();
    end
    // about 76 cycles of traffic; the 2000-cycle limit means a hang
    initial begin
        #8000;
        miscompares++;
        test_done();
    end
endmodule : tb_stack_agu
`default_nettype wire
